// [hw/nbp_pkg.sv]
// package for the nor flash block-map and protect host controller
package nbp_pkg;
    localparam int CLK_NS = 10;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // timing
    localparam int RST_PULSE_NS = 500;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_IDLE_NS = 500;
    localparam int READY_IDLE_CYC = (READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_BUSY_US = 20;
    localparam int READY_BUSY_CYC = (READY_BUSY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WR_PULSE_NS = 40;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_ACC_NS = 70;
    localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_DLY_NS = 90;
    localparam int BUSY_DLY_CYC = (BUSY_DLY_NS + CLK_NS - 1) / CLK_NS;
    // address fields
    localparam int GROUP_LSB = 12;
    localparam int GROUP_MSB = 19;
    localparam int BANK_LSB = 17;
    localparam int BANK_MSB = 19;
    localparam int A6_POS = 6;
    localparam int A1_POS = 1;
    localparam int A0_POS = 0;
    localparam int POLL_BIT = 7;
    // protect status values
    localparam logic [DATA_W-1:0] ST_PROT = 16'h0001;
    localparam logic [DATA_W-1:0] ST_UNPROT = 16'h0000;
    // block map
    localparam logic [2:0] BANK0 = 3'h0;
    localparam logic [2:0] BANK3 = 3'h7;
    localparam logic [6:0] SMALL_PER_END = 7'h08;
    localparam logic [6:0] LARGE_LOW_BASE = 7'h07;
    localparam logic [6:0] SMALL_HIGH_BASE = 7'h26;

    typedef enum logic [2:0] {
        NBP_OP_READ,
        NBP_OP_WRITE,
        NBP_OP_PROTECT,
        NBP_OP_UNPROTECT,
        NBP_OP_BYPASS_WRITE,
        NBP_OP_QUAD_WRITE,
        NBP_OP_RESET
    } nbp_op_t;

    typedef struct packed {
        nbp_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nbp_req_t;

    typedef struct packed {
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic reset_b;
        logic hv_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
    } nbp_pins_t;
endpackage

// [hw/nbp_host.sv]
// host controller driving the multibank nor flash pins
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] protect verify read at A6 low, A1 high, A0 low; 01h means protected
// [R2] unprotect drives A6 high, A1 high, A0 low; expects 00h on verify
// [R3] target group given on address lines 12 to 19 only
// [R4] status polling after a write uses that write's bank on lines 17 to 19
// [R5] reset during busy routine: wait 20 us before reading data
// [R6] reset while idle: wait 500 ns before reading data
// [R7] unlock-bypass commands only with high programming voltage applied
// [R8] quad-word program only with high voltage; voltage may stay across pulses
// [R9] 46 erase blocks, four banks, eight 4K blocks each end, 32K middle
// [R10] polling bit reads complement of written data until routine ends
// [R11] treat ready_busy_output busy as blocking a new operation
module nbp_host
    import nbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire nbp_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic rsp_ok,
    output logic [5:0] rsp_block,
    output nbp_pins_t pins,
    input wire logic [DATA_W-1:0] dq_i,
    input wire logic ready_busy_output
);

    typedef enum logic [2:0] {S_IDLE, S_WR, S_GAP, S_RD, S_POLL, S_RST, S_WAIT} nbp_state_t;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    nbp_state_t st_q, st_d;
    nbp_req_t cur_q, cur_d;
    nbp_pins_t pins_q, pins_d;
    logic [11:0] cnt_q, cnt_d;
    logic rv_q, rv_d, ok_q, ok_d, busy_seen_q, busy_seen_d;
    logic [DATA_W-1:0] rd_q, rd_d;
    logic [5:0] blk_q, blk_d;
    logic [6:0] blk_calc;
    logic rdy_q, rdy_d;

    // block index from word address
    always_comb begin
        logic [2:0] hi;
        hi = cur_q.addr[BANK_MSB:BANK_LSB];
        if (hi == BANK0 && cur_q.addr[16:15] == 2'h0) begin
            blk_calc = {4'h0, cur_q.addr[14:12]}; // [R9]
        end else if (hi == BANK3 && cur_q.addr[16:15] == 2'h3) begin
            blk_calc = SMALL_HIGH_BASE + {4'h0, cur_q.addr[14:12]}; // [R9]
        end else begin
            blk_calc = LARGE_LOW_BASE + {2'h0, cur_q.addr[19:15]}; // [R9]
        end
    end

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        pins_d = pins_q;
        cnt_d = cnt_q;
        rv_d = 1'b0;
        ok_d = ok_q;
        rd_d = rd_q;
        blk_d = blk_q;
        busy_seen_d = busy_seen_q;
        rdy_d = 1'b0;
        case (st_q)
            S_IDLE: begin
                pins_d.ce_b = 1'b1;
                pins_d.oe_b = 1'b1;
                pins_d.we_b = 1'b1;
                pins_d.dq_oe = 1'b0;
                rdy_d = ready_busy_output; // [R11]
                if (req_valid && rdy_q && ready_busy_output) begin
                    cur_d = req;
                    rdy_d = 1'b0;
                    pins_d.addr = req.addr;
                    pins_d.dq_o = req.data;
                    cnt_d = 12'h0;
                    case (req.op)
                        NBP_OP_READ: st_d = S_RD;
                        NBP_OP_RESET: begin
                            busy_seen_d = ~ready_busy_output;
                            pins_d.reset_b = 1'b0;
                            st_d = S_RST;
                        end
                        NBP_OP_PROTECT, NBP_OP_UNPROTECT: begin
                            pins_d.addr[GROUP_MSB:GROUP_LSB] = req.addr[GROUP_MSB:GROUP_LSB]; // [R3]
                            pins_d.addr[A6_POS] = (req.op == NBP_OP_UNPROTECT); // [R1] [R2]
                            pins_d.addr[A1_POS] = 1'b1;
                            pins_d.addr[A0_POS] = 1'b0;
                            pins_d.hv_en = 1'b1;
                            st_d = S_WR;
                        end
                        NBP_OP_BYPASS_WRITE, NBP_OP_QUAD_WRITE: begin
                            pins_d.hv_en = 1'b1; // [R7] [R8]
                            st_d = S_GAP;
                        end
                        default: begin
                            pins_d.hv_en = 1'b0;
                            st_d = S_WR;
                        end
                    endcase
                end
            end
            S_GAP: begin
                // voltage settles one write pulse ahead of the command
                cnt_d = cnt_q + 12'h1;
                if (cnt_q >= 12'(WR_PULSE_CYC - 1)) begin
                    cnt_d = 12'h0;
                    st_d = S_WR;
                end
            end
            S_WR: begin
                pins_d.ce_b = 1'b0;
                pins_d.we_b = 1'b0;
                pins_d.dq_oe = 1'b1;
                cnt_d = cnt_q + 12'h1;
                if (cnt_q >= 12'(WR_PULSE_CYC - 1)) begin
                    pins_d.we_b = 1'b1;
                    pins_d.ce_b = 1'b1;
                    cnt_d = 12'h0;
                    if (cur_q.op == NBP_OP_PROTECT || cur_q.op == NBP_OP_UNPROTECT) begin
                        st_d = S_RD;
                    end else begin
                        pins_d.dq_oe = 1'b0;
                        pins_d.addr[BANK_MSB:BANK_LSB] = cur_q.addr[BANK_MSB:BANK_LSB]; // [R4]
                        st_d = S_POLL;
                    end
                end
            end
            S_RD: begin
                pins_d.dq_oe = 1'b0;
                pins_d.ce_b = 1'b0;
                pins_d.oe_b = 1'b0;
                cnt_d = cnt_q + 12'h1;
                if (cnt_q >= 12'(RD_ACC_CYC)) begin
                    rd_d = dq_i;
                    pins_d.ce_b = 1'b1;
                    pins_d.oe_b = 1'b1;
                    pins_d.hv_en = 1'b0;
                    if (cur_q.op == NBP_OP_PROTECT) begin
                        ok_d = (dq_i == ST_PROT); // [R1]
                    end else if (cur_q.op == NBP_OP_UNPROTECT) begin
                        ok_d = (dq_i == ST_UNPROT); // [R2]
                    end else begin
                        ok_d = 1'b1;
                    end
                    rv_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            S_POLL: begin
                // wait past the busy delay, then poll until true data appears
                pins_d.ce_b = 1'b0;
                pins_d.oe_b = 1'b0;
                // a reset request may abort the running routine
                rdy_d = req_valid && req.op == NBP_OP_RESET; // [R5]
                if (req_valid && rdy_q && req.op == NBP_OP_RESET) begin
                    cur_d = req;
                    rdy_d = 1'b0;
                    busy_seen_d = ~ready_busy_output; // [R5]
                    pins_d.ce_b = 1'b1;
                    pins_d.oe_b = 1'b1;
                    pins_d.reset_b = 1'b0;
                    cnt_d = 12'h0;
                    st_d = S_RST;
                end else if (cnt_q < 12'(BUSY_DLY_CYC + RD_ACC_CYC)) begin
                    cnt_d = cnt_q + 12'h1;
                end else if (ready_busy_output
                        && dq_i[POLL_BIT] == cur_q.data[POLL_BIT]) begin // [R10] [R11]
                    rd_d = dq_i;
                    ok_d = 1'b1;
                    rv_d = 1'b1;
                    pins_d.ce_b = 1'b1;
                    pins_d.oe_b = 1'b1;
                    if (cur_q.op != NBP_OP_BYPASS_WRITE && cur_q.op != NBP_OP_QUAD_WRITE) begin
                        pins_d.hv_en = 1'b0;
                    end
                    st_d = S_IDLE;
                end
            end
            S_RST: begin
                cnt_d = cnt_q + 12'h1;
                if (cnt_q >= 12'(RST_PULSE_CYC - 1)) begin
                    pins_d.reset_b = 1'b1;
                    pins_d.hv_en = 1'b0;
                    cnt_d = 12'h0;
                    st_d = S_WAIT;
                end
            end
            S_WAIT: begin
                cnt_d = cnt_q + 12'h1;
                if ((busy_seen_q && cnt_q >= 12'(READY_BUSY_CYC - RST_PULSE_CYC)) // [R5]
                        || (!busy_seen_q && cnt_q >= 12'(READY_IDLE_CYC))) begin // [R6]
                    ok_d = 1'b1;
                    rv_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        blk_d = (rv_d) ? blk_calc[5:0] : blk_q;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            cur_q <= '0;
            pins_q <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, reset_b: 1'b1, hv_en: 1'b0,
                        addr: '0, dq_o: '0, dq_oe: 1'b0};
            cnt_q <= 12'h0;
            rv_q <= 1'b0;
            ok_q <= 1'b0;
            rd_q <= '0;
            blk_q <= 6'h0;
            busy_seen_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            pins_q <= pins_d;
            cnt_q <= cnt_d;
            rv_q <= rv_d;
            ok_q <= ok_d;
            rd_q <= rd_d;
            blk_q <= blk_d;
            busy_seen_q <= busy_seen_d;
            rdy_q <= rdy_d;
        end
    end

    assign req_ready = rdy_q;
    assign rsp_valid = rv_q;
    assign rsp_data = rd_q;
    assign rsp_ok = ok_q;
    assign rsp_block = blk_q;
    assign pins = pins_q;

endmodule

`default_nettype wire

// [test/nbp_host_props.sv]
// assertions on the nor host controller ports
`timescale 1ns/1ns
`default_nettype none
module nbp_host_props
    import nbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire nbp_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_data,
    input wire logic rsp_ok,
    input wire nbp_pins_t pins,
    input wire logic ready_busy_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    nbp_op_t op_q;
    logic [ADDR_W-1:0] ad_q;
    always_ff @(posedge clk) begin
        if (req_valid && req_ready) begin
            op_q <= req.op;
            ad_q <= req.addr;
        end
    end
    property p_rdy; !$past(ready_busy_output) && !($past(req_valid) && $past(req.op) == NBP_OP_RESET)
        |-> !req_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready while busy");
    property p_prot; !pins.we_b && op_q == NBP_OP_PROTECT
        |-> !pins.addr[6] && pins.addr[1:0] == 2'h2 && pins.addr[19:12] == ad_q[19:12]; endproperty
    a_prot: assert property (p_prot) else $error("protect addr");
    property p_unp; !pins.we_b && op_q == NBP_OP_UNPROTECT
        |-> pins.addr[6] && pins.addr[1:0] == 2'h2 && pins.addr[19:12] == ad_q[19:12]; endproperty
    a_unp: assert property (p_unp) else $error("unprotect addr");
    property p_hv; !pins.we_b && op_q inside {NBP_OP_BYPASS_WRITE, NBP_OP_QUAD_WRITE} |-> pins.hv_en; endproperty
    a_hv: assert property (p_hv) else $error("no high voltage");
    property p_bank; !pins.oe_b && op_q == NBP_OP_WRITE |-> pins.addr[19:17] == ad_q[19:17]; endproperty
    a_bank: assert property (p_bank) else $error("poll bank");
    property p_rpw; $fell(pins.reset_b) |-> ##49 !pins.reset_b; endproperty
    a_rpw: assert property (p_rpw) else $error("reset pulse short");
    property p_rrd; $rose(pins.reset_b) |-> pins.oe_b [*8]; endproperty
    a_rrd: assert property (p_rrd) else $error("read too early");
    property p_okp; rsp_valid && op_q == NBP_OP_PROTECT |-> rsp_ok == (rsp_data == ST_PROT); endproperty
    a_okp: assert property (p_okp) else $error("protect status");
    property p_oku; rsp_valid && op_q == NBP_OP_UNPROTECT |-> rsp_ok == (rsp_data == ST_UNPROT); endproperty
    a_oku: assert property (p_oku) else $error("unprotect status");
endmodule
`default_nettype wire

// [test/nbp_flash_model.sv]
// behavioural model of the flash device
`timescale 1ns/1ns
`default_nettype none
module nbp_flash_model
    import nbp_pkg::*;
#(parameter int BUSY_CYC = 40)
(
    input wire logic clk,
    input wire nbp_pins_t pins,
    output logic [DATA_W-1:0] dq_i,
    output logic ready_busy_output
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [255:0] prot = '0;
    logic ver = 0, we_q = 1, oe_q = 1;
    int busy = 0;
    initial dq_i = '0;
    assign ready_busy_output = (busy == 0);
    always @(posedge clk) begin
        we_q <= pins.we_b;
        oe_q <= pins.oe_b;
        if (pins.oe_b && !oe_q) ver <= 0;
        if (!pins.reset_b) begin
            busy <= 0;
            ver <= 0;
        end else if (busy > 0) busy <= busy - 1;
        if (pins.we_b && !we_q && pins.reset_b) begin
            if (pins.addr[1:0] == 2'h2) begin
                prot[pins.addr[19:12]] <= !pins.addr[6];
                ver <= 1;
            end else begin
                mem[pins.addr] = pins.dq_o;
                busy <= BUSY_CYC;
            end
        end
        if (!pins.ce_b && !pins.oe_b) begin
            if (ver) dq_i <= {15'h0, prot[pins.addr[19:12]]};
            else dq_i <= (mem.exists(pins.addr) ? mem[pins.addr] : 16'h0) ^ (busy > 0 ? 16'h0080 : 16'h0);
        end else dq_i <= ~dq_i;
    end
endmodule
`default_nettype wire

// [test/test_nbp_host.sv]
// self-checking bench for the nor host controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("mismatch at %0t: %h not %h", $time, a, b); end end
module test_nbp_host;
    import nbp_pkg::*;
    logic clk, rst_b, req_valid, req_ready, rsp_valid, rsp_ok, rdy;
    nbp_req_t req;
    logic [DATA_W-1:0] rsp_data, dq;
    logic [5:0] rsp_block;
    nbp_pins_t pins;
    int miscompares = 0, tests_run = 0, cyc;
    nbp_host nbp_host_inst(.clk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .rsp_ok,
        .rsp_block, .pins, .dq_i(dq), .ready_busy_output(rdy));
    nbp_flash_model #(.BUSY_CYC(40)) nbp_flash_model_inst(.clk, .pins, .dq_i(dq), .ready_busy_output(rdy));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_op(nbp_op_t op, logic [19:0] a, logic [15:0] d);
        req_valid <= 1;
        req <= '{op, a, d};
        cyc = 0;
        do @(posedge clk); while (!req_ready && ++cyc < 9000);
        req_valid <= 0;
        cyc = 0;
        do @(posedge clk); while (!rsp_valid && ++cyc < 9000);
        `CHK(cyc < 9000, 1'b1)
    endtask
    task automatic t_read;
        logic [19:0] a [6] = '{20'h00000, 20'h07fff, 20'h08000, 20'hf7fff, 20'hf8000, 20'hfffff};
        logic [5:0] b [6] = '{6'h00, 6'h07, 6'h08, 6'h25, 6'h26, 6'h2d};
        foreach (a[i]) begin
            do_op(NBP_OP_READ, a[i], 16'h0);
            `CHK(rsp_block, b[i])
        end
        $display("read map done");
    endtask
    task automatic t_write;
        logic [15:0] d [2] = '{16'ha5c3, 16'h5a3c};
        foreach (d[i]) begin
            do_op(NBP_OP_WRITE, 20'h50003, d[i]);
            `CHK(rsp_data, d[i])
            do_op(NBP_OP_READ, 20'h50003, 16'h0);
            `CHK(rsp_data, d[i])
        end
        $display("write poll done");
    endtask
    task automatic t_prot;
        do_op(NBP_OP_PROTECT, 20'h34002, 16'h0);
        `CHK(rsp_data, ST_PROT)
        `CHK(rsp_ok, 1'b1)
        do_op(NBP_OP_UNPROTECT, 20'h34002, 16'h0);
        `CHK(rsp_data, ST_UNPROT)
        `CHK(rsp_ok, 1'b1)
        $display("protect done");
    endtask
    task automatic t_hv;
        do_op(NBP_OP_BYPASS_WRITE, 20'h90001, 16'h1234);
        `CHK(rsp_data, 16'h1234)
        do_op(NBP_OP_QUAD_WRITE, 20'hc0001, 16'h00ff);
        do_op(NBP_OP_QUAD_WRITE, 20'hc0003, 16'hff00);
        `CHK(pins.hv_en, 1'b1)
        do_op(NBP_OP_READ, 20'hc0001, 16'h0);
        `CHK(rsp_data, 16'h00ff)
        $display("accelerate done");
    endtask
    task automatic t_rst;
        do_op(NBP_OP_RESET, 20'h0, 16'h0);
        `CHK(cyc >= 99, 1'b1)
        do_op(NBP_OP_READ, 20'h50003, 16'h0);
        `CHK(rsp_data, 16'h5a3c)
        $display("reset done");
    endtask
    task automatic t_abort;
        req_valid <= 1;
        req <= '{NBP_OP_WRITE, 20'h60005, 16'h0f0f};
        cyc = 0;
        do @(posedge clk); while (!req_ready && ++cyc < 9000);
        req <= '{NBP_OP_RESET, 20'h60005, 16'h0};
        cyc = 0;
        do @(posedge clk); while (!req_ready && ++cyc < 9000);
        req_valid <= 0;
        cyc = 0;
        do @(posedge clk); while (!rsp_valid && ++cyc < 9000);
        `CHK(cyc < 9000, 1'b1)
        `CHK(cyc >= READY_BUSY_CYC - 1, 1'b1)
        `CHK(pins.reset_b, 1'b1)
        do_op(NBP_OP_READ, 20'h50003, 16'h0);
        `CHK(rsp_data, 16'h5a3c)
        $display("abort done");
    endtask
    initial begin
        rst_b = 0;
        req_valid = 0;
        req = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        t_read;
        t_write;
        t_prot;
        t_hv;
        t_rst;
        t_abort;
        complete_run;
    end
    initial begin
        #200000;
        miscompares++;
        complete_run;
    end
endmodule
bind nbp_host nbp_host_props nbp_host_props_inst(.clk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_data, .rsp_ok, .pins, .ready_busy_output);
`default_nettype wire
